/* rtl/ccg_cfg.svh */
// Purpose: Constants for the codec clock generator and pin logic
// Assumes: Included by ccg_top.sv only
// Notes:   Register indices; byte address is index times four
`ifndef CCG_CFG_SVH
`define CCG_CFG_SVH
// ============================================================
// Register indices (byte address = index * 4)
`define CCG_IDX_PM1      6'h01
`define CCG_IDX_OUTEN    6'h03
`define CCG_IDX_CLKSEL   6'h06
`define CCG_IDX_SRATE    6'h07
`define CCG_IDX_PINFN    6'h08
`define CCG_IDX_PLLINT   6'h24
`define CCG_IDX_FRACH    6'h25
`define CCG_IDX_FRACM    6'h26
`define CCG_IDX_FRACL    6'h27
`define CCG_IDX_BOOST    6'h31
`define CCG_IDX_STATUS   6'h3F
// ============================================================
// Reset values
`define CCG_RST_PM1      9'h000
`define CCG_RST_OUTEN    9'h000
`define CCG_RST_CLKSEL   9'h140
`define CCG_RST_SRATE    9'h000
`define CCG_RST_PINFN    9'h000
`define CCG_RST_PLLINT   9'h008
`define CCG_RST_FRACH    9'h00C
`define CCG_RST_FRACM    9'h093
`define CCG_RST_FRACL    9'h0E9
`define CCG_RST_BOOST    9'h000
// ============================================================
// Writable bit masks (reserved bits read zero)
`define CCG_MSK_CLKSEL   9'h1FD
`define CCG_MSK_SRATE    9'h00F
`define CCG_MSK_PINFN    9'h03F
`define CCG_MSK_PLLINT   9'h01F
`define CCG_MSK_FRACH    9'h03F
// ============================================================
// Field positions
`define CCG_B_PLL_POWER_ENABLE      5
`define CCG_B_SPKP       5
`define CCG_B_SPKN       6
`define CCG_B_MOUT       7
`define CCG_B_CLOCK_SOURCE_SELECT       8
`define CCG_B_MASTER     0
`define CCG_B_SLOW_TIMER_ENABLE     0
`define CCG_B_POL        3
`define CCG_B_HALVE      4
`define CCG_B_TEMP_SENSE_ENABLE       1
// ============================================================
// Timing
`define CCG_SLOW_PERIOD_MS   128
`define CCG_INTERNAL_MASTER_CLOCK_PER_FS     256
`define CCG_REF_RATE_KHZ     48
`define CCG_OSC_DIV          4
`endif

/* rtl/ccg_pkg.sv */
// Purpose: Types for the codec clock generator
// Assumes: Used by ccg_top only
// Notes:   Whole state of the top is one packed struct
package ccg_pkg;
    // ============================================================
    // Pin function codes
    typedef enum logic [2:0] {
        CCG_PIN_CSB, CCG_PIN_JACK, CCG_PIN_TEMP, CCG_PIN_MUTE,
        CCG_PIN_CLK, CCG_PIN_LOCK, CCG_PIN_HIGH, CCG_PIN_LOW
    } ccg_pin_fn_t;
    typedef struct packed {
        logic [8:0] r_pm1, r_out, r_clk, r_sr, r_pin;
        logic [8:0] r_int, r_fh, r_fm, r_fl, r_bst;
        logic pready, pslverr;
        logic [31:0] prdata;
        logic ref_half, ref_tick;
        logic [1:0] osc_cnt;
        logic fpll_tick;
        logic [3:0] pre_cnt;
        logic internal_master_clock_tick;
        logic [7:0] fs_cnt;
        logic fs;
        logic [6:0] bclk_cnt;
        logic bclk;
        logic [21:0] slow_cnt;
        logic slow_tick, jack_samp, jack_lvl;
        logic lock_s1, lock_s2, temp_flag;
        logic [1:0] pin_div_cnt;
        logic pin_clk, pin_out, pin_oe_n;
        logic spk_pos, spk_neg, mono;
    } ccg_state_t;
endpackage

/* rtl/ccg_top.sv */
// Purpose: Clock generation, slow timer and multi-function pin logic
// Assumes: APB slave, one 10 MHz reference clock, PLL analog outside
// Notes:   Clocks inside run on clk_i: ticks are one-cycle enable pulses, bit and pin clocks are toggled levels
`include "ccg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ccg_top #(
    parameter int unsigned SLOW_TICKS_48K =
        `CCG_SLOW_PERIOD_MS * `CCG_INTERNAL_MASTER_CLOCK_PER_FS * `CCG_REF_RATE_KHZ
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic [31:0]      prdata_o,
    // Analog and system inputs
    input  wire logic        control_two_wire_i,
    input  wire logic        pll_osc_tick_i,
    input  wire logic        pll_locked_i,
    input  wire logic        temp_alarm_i,
    input  wire logic        analog_mute_flag_i,
    input  wire logic        frame_short_i,
    // Multi-function pin
    input  wire logic        multi_function_pin_i,
    output logic             multi_function_pin_o,
    output logic             multi_function_pin_oe_n_o,
    // Audio interface clocks
    output logic             frame_sync_o,
    output logic             frame_sync_oe_n_o,
    output logic             bit_clock_o,
    output logic             bit_clock_oe_n_o,
    output logic             internal_master_clock_o,
    // PLL and analog controls
    output logic             pll_power_enable_o,
    output logic             pll_ref_tick_o,
    output logic [3:0]       pll_integer_value_o,
    output logic [23:0]      pll_fraction_word_o,
    output logic             temp_sense_enable_o,
    output logic             speaker_pos_enable_o,
    output logic             speaker_neg_enable_o,
    output logic             mono_out_enable_o
);
    // ============================================================
    // Helper functions
    // Register select code from byte address, 15 when unmapped
    function automatic logic [3:0] reg_sel(input logic [7:0] a);
        if (a[1:0] != 2'h0) begin
            return 4'hF;
        end
        case (a[7:2])
            `CCG_IDX_PM1:    return 4'h0;
            `CCG_IDX_OUTEN:  return 4'h1;
            `CCG_IDX_CLKSEL: return 4'h2;
            `CCG_IDX_SRATE:  return 4'h3;
            `CCG_IDX_PINFN:  return 4'h4;
            `CCG_IDX_PLLINT: return 4'h5;
            `CCG_IDX_FRACH:  return 4'h6;
            `CCG_IDX_FRACM:  return 4'h7;
            `CCG_IDX_FRACL:  return 4'h8;
            `CCG_IDX_BOOST:  return 4'h9;
            `CCG_IDX_STATUS: return 4'hA;
            default:         return 4'hF;
        endcase
    endfunction

    // Prescaler terminal count: divide by 1,2,3,4,6,8,12,16
    function automatic logic [3:0] pre_term(input logic [2:0] c);
        case (c)
            3'h0:    return 4'h0;
            3'h1:    return 4'h1;
            3'h2:    return 4'h2;
            3'h3:    return 4'h3;
            3'h4:    return 4'h5;
            3'h5:    return 4'h7;
            3'h6:    return 4'hB;
            default: return 4'hF;
        endcase
    endfunction

    // Sample rate in kHz per code; spare codes read as lowest rate
    function automatic logic [5:0] rate_khz(input logic [2:0] c);
        case (c)
            3'h0:    return 6'h30;
            3'h1:    return 6'h20;
            3'h2:    return 6'h18;
            3'h3:    return 6'h10;
            3'h4:    return 6'h0C;
            default: return 6'h08;
        endcase
    endfunction

    // ============================================================
    // State
    ccg_pkg::ccg_state_t q_reg;
    ccg_pkg::ccg_state_t q_next;
    logic [3:0]          wsel;
    logic [3:0]          rsel;
    logic [8:0]          wd;
    logic                jack_raw;
    logic                jack_on;
    logic                master;
    logic [21:0]         slow_lim;
    logic [3:0]          pfn_sel;
    logic                pin_val;

    // Next-state logic for everything
    always_comb begin
        q_next   = q_reg;
        wsel     = reg_sel(paddr_i);
        rsel     = wsel;
        wd       = pwdata_i[8:0];
        master   = q_reg.r_clk[`CCG_B_MASTER];
        jack_raw = multi_function_pin_i ^ q_reg.r_pin[`CCG_B_POL];
        jack_on  = (q_reg.r_pin[2:0] == 3'h1) && control_two_wire_i;
        // 128 ms of master clock ticks at the programmed rate
        slow_lim = 22'(SLOW_TICKS_48K * rate_khz(q_reg.r_sr[3:1])
                   / `CCG_REF_RATE_KHZ - 1);
        pfn_sel  = {1'b0, q_reg.r_pin[2:0]};

        // APB: answer in the first access cycle, never waits
        q_next.pready  = psel_i && !penable_i;
        q_next.pslverr = psel_i && !penable_i && (rsel == 4'hF);
        if (psel_i && !penable_i) begin
            case (rsel)
                4'h0:    q_next.prdata = {23'h0, q_reg.r_pm1};
                4'h1:    q_next.prdata = {23'h0, q_reg.r_out};
                4'h2:    q_next.prdata = {23'h0, q_reg.r_clk};
                4'h3:    q_next.prdata = {23'h0, q_reg.r_sr};
                4'h4:    q_next.prdata = {23'h0, q_reg.r_pin};
                4'h5:    q_next.prdata = {23'h0, q_reg.r_int};
                4'h6:    q_next.prdata = {23'h0, q_reg.r_fh};
                4'h7:    q_next.prdata = {23'h0, q_reg.r_fm};
                4'h8:    q_next.prdata = {23'h0, q_reg.r_fl};
                4'h9:    q_next.prdata = {23'h0, q_reg.r_bst};
                4'hA:    q_next.prdata = {27'h0, q_reg.pin_out, q_reg.slow_tick,
                                          q_reg.temp_flag, q_reg.lock_s2, q_reg.jack_lvl};
                default: q_next.prdata = 32'h0;
            endcase
        end
        // Write takes effect only at the completing access edge
        if (psel_i && penable_i && pwrite_i && q_reg.pready) begin
            case (wsel)
                4'h0:    q_next.r_pm1 = wd;
                4'h1:    q_next.r_out = wd;
                4'h2:    q_next.r_clk = wd & `CCG_MSK_CLKSEL;
                4'h3:    q_next.r_sr  = wd & `CCG_MSK_SRATE;
                4'h4:    q_next.r_pin = wd & `CCG_MSK_PINFN;
                4'h5:    q_next.r_int = wd & `CCG_MSK_PLLINT;
                4'h6:    q_next.r_fh  = wd & `CCG_MSK_FRACH;
                4'h7:    q_next.r_fm  = wd;
                4'h8:    q_next.r_fl  = wd;
                4'h9:    q_next.r_bst = wd;
                default: q_next.r_pm1 = q_reg.r_pm1;
            endcase
        end

        // PLL reference enable, halved on request
        q_next.ref_half = !q_reg.ref_half;
        q_next.ref_tick = !q_reg.r_int[`CCG_B_HALVE] || !q_reg.ref_half;

        // Prescaler input: reference every cycle, or oscillator over four
        q_next.fpll_tick = 1'b0;
        if (q_reg.r_clk[`CCG_B_CLOCK_SOURCE_SELECT]) begin
            if (pll_osc_tick_i) begin
                q_next.osc_cnt   = q_reg.osc_cnt + 2'h1;
                q_next.fpll_tick = (q_reg.osc_cnt == 2'(`CCG_OSC_DIV - 1));
            end
        end else begin
            q_next.osc_cnt   = 2'h0;
            q_next.fpll_tick = 1'b1;
        end

        // Master clock prescaler and pin clock divider
        q_next.internal_master_clock_tick = 1'b0;
        if (q_reg.fpll_tick) begin
            if (q_reg.pre_cnt >= pre_term(q_reg.r_clk[7:5])) begin
                q_next.pre_cnt    = 4'h0;
                q_next.internal_master_clock_tick = 1'b1;
            end else begin
                q_next.pre_cnt = q_reg.pre_cnt + 4'h1;
            end
            if (q_reg.pin_div_cnt >= q_reg.r_pin[5:4]) begin
                q_next.pin_div_cnt = 2'h0;
                q_next.pin_clk     = !q_reg.pin_clk;
            end else begin
                q_next.pin_div_cnt = q_reg.pin_div_cnt + 2'h1;
            end
        end

        // Frame sync at master clock over 256, bit clock divided
        if (!master) begin
            q_next.fs_cnt   = 8'h0;
            q_next.fs       = 1'b0;
            q_next.bclk_cnt = 7'h0;
            q_next.bclk     = 1'b0;
        end else if (q_reg.internal_master_clock_tick) begin
            q_next.fs_cnt = q_reg.fs_cnt + 8'h1;
            q_next.fs     = frame_short_i ? (q_reg.fs_cnt == 8'hFF)
                                          : (q_reg.fs_cnt >= 8'h7F);
            if (q_reg.bclk_cnt >= 7'((8'h1 << q_reg.r_clk[4:2]) - 8'h1)) begin
                q_next.bclk_cnt = 7'h0;
                q_next.bclk     = !q_reg.bclk;
            end else begin
                q_next.bclk_cnt = q_reg.bclk_cnt + 7'h1;
            end
        end

        // Slow timer: held clear until software enables it
        q_next.slow_tick = 1'b0;
        if (!q_reg.r_sr[`CCG_B_SLOW_TIMER_ENABLE]) begin
            q_next.slow_cnt = 22'h0;
        end else if (q_reg.internal_master_clock_tick) begin
            if (q_reg.slow_cnt >= slow_lim) begin
                q_next.slow_cnt  = 22'h0;
                q_next.slow_tick = 1'b1;
            end else begin
                q_next.slow_cnt = q_reg.slow_cnt + 22'h1;
            end
        end

        // Debounce: a level must hold over two slow ticks
        if (q_reg.slow_tick) begin
            q_next.jack_samp = jack_raw;
            if (jack_raw == q_reg.jack_samp) begin
                q_next.jack_lvl = jack_raw;
            end
        end

        // Lock synchroniser; temperature alarm takes one flop, gated by the sense enable
        q_next.lock_s1   = pll_locked_i;
        q_next.lock_s2   = q_reg.lock_s1;
        q_next.temp_flag = temp_alarm_i && q_reg.r_bst[`CCG_B_TEMP_SENSE_ENABLE];

        // Pin function decode
        case (ccg_pkg::ccg_pin_fn_t'(pfn_sel[2:0]))
            ccg_pkg::CCG_PIN_TEMP: pin_val = !q_reg.temp_flag;
            ccg_pkg::CCG_PIN_MUTE: pin_val = analog_mute_flag_i;
            ccg_pkg::CCG_PIN_CLK:  pin_val = q_reg.pin_clk;
            ccg_pkg::CCG_PIN_LOCK: pin_val = !q_reg.lock_s2;
            ccg_pkg::CCG_PIN_HIGH: pin_val = 1'b1;
            default:               pin_val = 1'b0;
        endcase
        q_next.pin_out  = pin_val ^ q_reg.r_pin[`CCG_B_POL];
        q_next.pin_oe_n = (pfn_sel[2:1] == 2'h0);

        // Output path selection from jack level
        if (jack_on) begin
            q_next.spk_pos = !q_reg.jack_lvl && q_reg.r_out[`CCG_B_SPKP];
            q_next.spk_neg = !q_reg.jack_lvl && q_reg.r_out[`CCG_B_SPKN];
            q_next.mono    = q_reg.jack_lvl && q_reg.r_out[`CCG_B_MOUT];
        end else begin
            q_next.spk_pos = q_reg.r_out[`CCG_B_SPKP];
            q_next.spk_neg = q_reg.r_out[`CCG_B_SPKN];
            q_next.mono    = q_reg.r_out[`CCG_B_MOUT];
        end
    end

    // Register the whole state
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            q_reg       <= '0;
            q_reg.r_pm1 <= `CCG_RST_PM1;
            q_reg.r_out <= `CCG_RST_OUTEN;
            q_reg.r_clk <= `CCG_RST_CLKSEL;
            q_reg.r_sr  <= `CCG_RST_SRATE;
            q_reg.r_pin <= `CCG_RST_PINFN;
            q_reg.r_int <= `CCG_RST_PLLINT;
            q_reg.r_fh  <= `CCG_RST_FRACH;
            q_reg.r_fm  <= `CCG_RST_FRACM;
            q_reg.r_fl  <= `CCG_RST_FRACL;
            q_reg.r_bst <= `CCG_RST_BOOST;
            q_reg.pin_oe_n <= 1'b1;  // Pin idles as chip-select input
        end else begin
            q_reg <= q_next;
        end
    end

    // ============================================================
    // Outputs, all from flops
    assign pready_o                  = q_reg.pready;
    assign pslverr_o                 = q_reg.pslverr;
    assign prdata_o                  = q_reg.prdata;
    assign multi_function_pin_o      = q_reg.pin_out;
    assign multi_function_pin_oe_n_o = q_reg.pin_oe_n;
    assign frame_sync_o              = q_reg.fs;
    assign frame_sync_oe_n_o         = !q_reg.r_clk[`CCG_B_MASTER];
    assign bit_clock_o               = q_reg.bclk;
    assign bit_clock_oe_n_o          = !q_reg.r_clk[`CCG_B_MASTER];
    assign internal_master_clock_o   = q_reg.internal_master_clock_tick;
    assign pll_power_enable_o        = q_reg.r_pm1[`CCG_B_PLL_POWER_ENABLE];
    assign pll_ref_tick_o            = q_reg.ref_tick;
    assign pll_integer_value_o       = q_reg.r_int[3:0];
    assign pll_fraction_word_o       = {q_reg.r_fh[5:0], q_reg.r_fm, q_reg.r_fl};
    assign temp_sense_enable_o       = q_reg.r_bst[`CCG_B_TEMP_SENSE_ENABLE];
    assign speaker_pos_enable_o      = q_reg.spk_pos;
    assign speaker_neg_enable_o      = q_reg.spk_neg;
    assign mono_out_enable_o         = q_reg.mono;

    // ============================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    property p_slow_off;
        !q_reg.r_sr[`CCG_B_SLOW_TIMER_ENABLE] |=> !q_reg.slow_tick [*2];
    endproperty
    a_slow_off: assert property (p_slow_off) else $error("slow tick while disabled");

    property p_slow_period;
        q_reg.slow_tick |-> $past(q_reg.slow_cnt) == $past(slow_lim);
    endproperty
    a_slow_period: assert property (p_slow_period) else $error("slow tick off period");

    property p_jack_off;
        !jack_on |=> speaker_pos_enable_o == $past(q_reg.r_out[`CCG_B_SPKP]);
    endproperty
    a_jack_off: assert property (p_jack_off) else $error("jack steering while inactive");

    property p_jack_path;
        jack_on |=> !(speaker_pos_enable_o && mono_out_enable_o)
                    && mono_out_enable_o == ($past(q_reg.jack_lvl) && $past(q_reg.r_out[`CCG_B_MOUT]));
    endproperty
    a_jack_path: assert property (p_jack_path) else $error("jack output steering wrong");

    property p_debounce;
        $changed(q_reg.jack_lvl) |-> $past(q_reg.slow_tick) && $past(q_reg.jack_samp) == q_reg.jack_lvl;
    endproperty
    a_debounce: assert property (p_debounce) else $error("jack level taken without two samples");

    property p_pin_fixed;
        (q_reg.r_pin[2:0] == 3'h6) |=> multi_function_pin_o == !$past(q_reg.r_pin[`CCG_B_POL])
                                       && !multi_function_pin_oe_n_o;
    endproperty
    a_pin_fixed: assert property (p_pin_fixed) else $error("pin drive-high decode wrong");

    property p_temp;
        1'b1 |=> q_reg.temp_flag == ($past(temp_alarm_i) && $past(q_reg.r_bst[`CCG_B_TEMP_SENSE_ENABLE]));
    endproperty
    a_temp: assert property (p_temp) else $error("temperature flag wrong");

    property p_lock_sync;
        1'b1 |=> ##1 q_reg.lock_s2 == $past(pll_locked_i, 2);
    endproperty
    a_lock_sync: assert property (p_lock_sync) else $error("lock synchroniser depth wrong");

    property p_fs_step;
        $changed(frame_sync_o) && $past(master) && master |-> $past(q_reg.internal_master_clock_tick);
    endproperty
    a_fs_step: assert property (p_fs_step) else $error("frame sync moved off master tick");

    property p_osc_quarter;
        q_reg.r_clk[`CCG_B_CLOCK_SOURCE_SELECT] && $past(q_reg.r_clk[`CCG_B_CLOCK_SOURCE_SELECT]) && q_reg.fpll_tick
            |-> $past(pll_osc_tick_i) && $past(q_reg.osc_cnt) == 2'h3;
    endproperty
    a_osc_quarter: assert property (p_osc_quarter) else $error("oscillator not divided by four");

    c_slow: cover property (q_reg.slow_tick);
    c_jack: cover property (jack_on && $rose(q_reg.jack_lvl));
    c_fs:   cover property (master && $rose(frame_sync_o));
    c_pclk: cover property ($changed(q_reg.pin_clk) && q_reg.r_pin[5:4] == 2'h3);
endmodule // ccg_top
`default_nettype wire

/* sim/ccg_far_model.sv */
// Purpose: Far-side model: PLL oscillator, lock flag, jack plug
// Assumes: Oscillator pulses every second reference cycle
// Notes:   Lock comes LOCK_TICKS + 1 pulses after power-up
`timescale 1ns/1ps
`default_nettype none
module ccg_far_model #(
    parameter int LOCK_TICKS = 8
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // Controls from device and bench
    input  wire logic pll_power_enable_i,
    input  wire logic jack_plugged_i,
    // Far-side levels
    output logic      osc_tick_o,
    output logic      locked_o,
    output logic      pin_o
);
    int cnt;
    // ============================================================
    // Lock only after steady power, so an early read shows unlocked
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || !pll_power_enable_i) begin
            cnt      <= 0;
            locked_o <= 1'b0;
        end else if (osc_tick_o) begin
            cnt      <= cnt + 1;
            locked_o <= (cnt >= LOCK_TICKS);
        end
        // Oscillator scaled down; each tick stands for an in-range period
        osc_tick_o <= reset_n_i && !osc_tick_o;
    end
    // Plug pulls the detect pin high
    assign pin_o = jack_plugged_i;
endmodule // ccg_far_model
`default_nettype wire

/* sim/tb_codec_clock_gen_and_jack_detect.sv */
// Purpose: Self-checking bench for ccg_top
// Assumes: 10 MHz clock, slow timer shortened to 48 master ticks
// Notes:   Register rows, pin rows, then jack and frame cases
`timescale 1ns/1ps
`default_nettype none
module tb_codec_clock_gen_and_jack_detect;
    logic        clk_i = 0, reset_n_i = 0, psel = 0, pen = 0, pwr = 0;
    logic [7:0]  pa = 0;
    logic [31:0] pwd = 0, prd, rd;
    logic        pready, perr, er, two_wire = 1, alarm = 0, mute = 1, plugged = 0;
    logic        osc, lock, pin, pin_o, pin_oe_n, fs, fs_oe_n, internal_master_clock;
    logic        pll_en, temp_sense_enable, spkp, spkn, mono, bclk, fshort = 0;
    logic [23:0] frac;
    logic [3:0]  pint;
    int          n_mismatch = 0, checked = 0, n, m, b;
    // ============================================================
    // Rows: address, reset value, read-back after all-ones write (bits 1:0 left clear for 8'h90)
    localparam logic [7:0] RA [10] = '{8'h04, 8'h0C, 8'h18, 8'h1C, 8'h20, 8'h90, 8'h94, 8'h98, 8'h9C, 8'hC4};
    localparam logic [8:0] RV [10] = '{9'h000, 9'h000, 9'h140, 9'h000, 9'h000, 9'h008, 9'h00C, 9'h093, 9'h0E9, 9'h000};
    localparam logic [8:0] RM [10] = '{9'h1FF, 9'h1FF, 9'h1FD, 9'h00F, 9'h03F, 9'h01C, 9'h03F, 9'h1FF, 9'h1FF, 9'h1FF};
    // Rows: pin function, driven level, output enable (low drives)
    localparam logic [2:0] PF [6] = '{3'h2, 3'h3, 3'h5, 3'h6, 3'h7, 3'h0};
    localparam logic       PP [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    localparam logic       PE [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    ccg_top #(.SLOW_TICKS_48K(48)) ccg_top_i (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(pa), .pwdata_i(pwd), .pready_o(pready), .pslverr_o(perr), .prdata_o(prd),
        .control_two_wire_i(two_wire), .pll_osc_tick_i(osc), .pll_locked_i(lock),
        .temp_alarm_i(alarm), .analog_mute_flag_i(mute), .frame_short_i(fshort),
        .multi_function_pin_i(pin), .multi_function_pin_o(pin_o), .multi_function_pin_oe_n_o(pin_oe_n),
        .frame_sync_o(fs), .frame_sync_oe_n_o(fs_oe_n), .bit_clock_o(bclk), .bit_clock_oe_n_o(),
        .internal_master_clock_o(internal_master_clock), .pll_power_enable_o(pll_en), .pll_ref_tick_o(),
        .pll_integer_value_o(pint), .pll_fraction_word_o(frac), .temp_sense_enable_o(temp_sense_enable),
        .speaker_pos_enable_o(spkp), .speaker_neg_enable_o(spkn), .mono_out_enable_o(mono));
    ccg_far_model ccg_far_model_i (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .pll_power_enable_i(pll_en),
        .jack_plugged_i(plugged), .osc_tick_o(osc), .locked_o(lock), .pin_o(pin));
    // ============================================================
    // Clock, 100 ns period
    initial forever #50 clk_i = ~clk_i;
    // Watchdog, well beyond the expected run length
    initial begin
        repeat (30000) @(posedge clk_i);
        n_mismatch++;
        results();
    end
    task automatic results;
        $display("Checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // APB transfer; pready, read data and error are taken at the rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        psel <= 1;
        pen  <= 0;
        pwr  <= w;
        pa   <= a;
        pwd  <= d;
        @(posedge clk_i);
        pen <= 1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) chk(pready, 1'b1);
        rd = prd;
        er = perr;
        psel <= 0;
        pen  <= 0;
        // Let the write settle before the caller looks at outputs
        @(negedge clk_i);
    endtask
    task automatic wait_mono(input logic v);
        for (m = 0; m < 1000 && mono !== v; m++) @(negedge clk_i);
        chk(mono, v);
        chk(spkp, !v);
        chk(spkn, !v);
    endtask
    // Counts master pulses and cycles until frame sync reaches v
    task automatic step_to(input logic v);
        for (int k = 0; k < 2000 && fs !== v; k++) begin
            @(negedge clk_i);
            n += (internal_master_clock === 1'b1);
            b += (bclk === 1'b1);
            m++;
        end
    endtask
    // ============================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1;
        chk(frac, 24'h3126E9);
        chk(pint, 4'h8);
        for (int i = 0; i < 10; i++) begin
            apb(0, RA[i], 0);
            chk(rd, RV[i]);
            apb(1, RA[i], (i == 5) ? 32'hFFFFFFFC : 32'hFFFFFFFF);
            apb(0, RA[i], 0);
            chk(rd, RM[i]);
        end
        chk(frac, 24'hFFFFFF);
        apb(0, 8'h08, 0);
        chk(er, 1'b1);
        apb(1, 8'h19, 0);
        chk(er, 1'b1);
        // Back to reference source, divide by three, slave, timer off
        apb(1, 8'h18, 32'h040);
        apb(1, 8'h1C, 0);
        apb(1, 8'h0C, 32'h0E0);
        apb(1, 8'hC4, 32'h002);
        chk(temp_sense_enable, 1'b1);
        for (int i = 0; i < 6; i++) begin
            apb(1, 8'h20, PF[i]);
            repeat (5) @(negedge clk_i);
            chk(pin_oe_n, PE[i]);
            if (!PE[i]) chk(pin_o, PP[i]);
        end
        // Pin clock, divide code 3: one toggle every four input ticks
        apb(1, 8'h20, 32'h034);
        repeat (8) @(negedge clk_i);
        n = 0;
        for (m = 0; m < 32; m++) begin
            er = pin_o;
            @(negedge clk_i);
            n += (pin_o !== er);
        end
        chk(n, 8);
        // Alarm reaches the pin unfiltered within the sync delay
        apb(1, 8'h20, 32'h002);
        @(posedge clk_i) alarm <= 1;
        repeat (4) @(negedge clk_i);
        chk(pin_o, 1'b0);
        // Jack steering: timer off first, so the level must not move
        apb(1, 8'h20, 32'h001);
        @(posedge clk_i) plugged <= 1;
        repeat (400) @(negedge clk_i);
        chk(mono, 1'b0);
        apb(1, 8'h1C, 32'h001);
        wait_mono(1);
        @(posedge clk_i) plugged <= 0;
        repeat (10) @(posedge clk_i);
        plugged <= 1;
        n = 0;
        for (m = 0; m < 400; m++) begin
            @(negedge clk_i);
            n += (mono !== 1'b1);
        end
        chk(n, 0);
        apb(1, 8'h20, 32'h009);
        wait_mono(0);
        @(posedge clk_i) two_wire <= 0;
        repeat (3) @(negedge clk_i);
        chk(mono, 1'b1);
        chk(spkp, 1'b1);
        // Master mode: one frame is 256 master ticks of 3 cycles
        chk(fs_oe_n, 1'b1);
        apb(1, 8'h18, 32'h041);
        repeat (2) @(negedge clk_i);
        chk(fs_oe_n, 1'b0);
        step_to(0);
        step_to(1);
        n = 0;
        m = 0;
        b = 0;
        step_to(0);
        step_to(1);
        chk(n, 256);
        chk(m, 768);
        chk(b, 384);
        // Short frame: sync high for one master tick only
        @(posedge clk_i) fshort <= 1;
        step_to(0);
        step_to(1);
        m = 0;
        step_to(0);
        chk(m, 3);
        results();
    end
endmodule // tb_codec_clock_gen_and_jack_detect
`default_nettype wire
